// *** hdl/dnc_ao_if.sv ***
// Purpose: Carries analog value selection between top and mux
// Assumes: Same clock on both sides
// Notes:   One instance per analog output
`timescale 1ns/1ps
interface dnc_ao_if;
    logic [15:0]         val1;
    logic [15:0]         val2;
    logic [14:0]         other;
    dnc_pkg::dnc_ao_sel_t sel;
    logic [14:0]         level;

    modport mux (input val1, val2, other, sel, output level);
    modport top (output val1, val2, other, sel, input level);
endinterface : dnc_ao_if

// *** hdl/dnc_ao_mux.sv ***
// Purpose: Selects and scales one analog output level
// Assumes: Register values are signed 16-bit
// Notes:   Negative values clamp to zero percent
`timescale 1ns/1ps
module dnc_ao_mux (
    input  wire logic i_mclk,  // System clock
    input  wire logic i_reset, // Sync reset
    dnc_ao_if.mux     ao       // Selection bundle
);
    // ------------------------------------------------------------
    // Clamp to 15-bit scale
    // ------------------------------------------------------------
    function automatic logic [14:0] scale15(input logic [15:0] v);
        scale15 = v[15] ? dnc_pkg::AO_ZERO : v[14:0];
    endfunction : scale15

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ao.level <= dnc_pkg::AO_ZERO;
        end else begin
            unique case (ao.sel)
                dnc_pkg::AO_SEL_VAL1:  ao.level <= scale15(ao.val1);
                dnc_pkg::AO_SEL_VAL2:  ao.level <= scale15(ao.val2);
                dnc_pkg::AO_SEL_OTHER: ao.level <= ao.other;
                default:               ao.level <= ao.other;
            endcase
        end
    end
endmodule : dnc_ao_mux

// *** hdl/dnc_cmd_regs.sv ***
// Purpose: Network command, setpoint and output value registers
// Assumes: All inputs come from logic on i_mclk
// Notes:   Panel port exists only to be refused
`timescale 1ns/1ps
module dnc_cmd_regs #(
    parameter int DO_N = 4,  // Discrete outputs
    parameter int FQ_W = 16  // Rated frequency width
) (
    input  wire logic                 i_mclk,       // 10 MHz clock
    input  wire logic                 i_reset,      // Sync reset
    // Network parameter port
    input  wire logic                 i_net_wr,     // Write strobe
    input  wire logic [2:0]           i_net_addr,   // Register index
    input  wire logic [15:0]          i_net_wdata,  // Write data
    output logic                      o_net_err,    // Unmapped write
    // Operator panel parameter port
    input  wire logic                 i_pan_wr,     // Write strobe
    input  wire logic [2:0]           i_pan_addr,   // Register index
    input  wire logic [15:0]          i_pan_wdata,  // Write data
    output logic                      o_pan_refused,// Write refused
    // Shared read port
    input  wire logic [2:0]           i_rd_addr,    // Read index
    output logic [15:0]               o_rd_data,    // Read data
    // Source selection settings
    input  wire logic                 i_cmd_src_net,// Commands from net
    input  wire logic                 i_ref_src_net,// Reference from net
    input  wire logic [DO_N-1:0]      i_do_sel_reg, // Output uses register
    input  wire logic [DO_N-1:0]      i_do_other,   // Other function level
    input  dnc_pkg::dnc_ao_sel_t      i_ao1_sel,    // Analog 1 function
    input  dnc_pkg::dnc_ao_sel_t      i_ao2_sel,    // Analog 2 function
    input  wire logic [14:0]          i_ao1_other,  // Analog 1 other level
    input  wire logic [14:0]          i_ao2_other,  // Analog 2 other level
    input  wire logic                 i_fault,      // Drive faulted
    input  wire logic [FQ_W-1:0]      i_rated_freq, // Motor rated frequency
    // Drive commands
    output logic                      o_run,        // Run on ramp
    output logic                      o_enable,     // General enable
    output logic                      o_inch,       // Inching function
    output logic                      o_remote,     // Remote mode
    output logic                      o_ramp2,      // Second ramp pair
    output logic                      o_quick_stop, // Quick stop
    output logic                      o_fault_reset,// Fault reset
    output logic                      o_cmd_active, // Net commands in use
    // Speed reference
    output logic                      o_ref_valid,  // Net reference in use
    output logic                      o_ref_fwd,    // Forward direction
    output logic [FQ_W-1:0]           o_ref_freq,   // Reference frequency
    // Outputs
    output logic [DO_N-1:0]           o_do,         // Discrete outputs
    output logic [14:0]               o_ao1,        // Analog output 1
    output logic [14:0]               o_ao2         // Analog output 2
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] cmd_q;
    logic [15:0] speed_q;
    logic [15:0] dout_q;
    logic [15:0] ao1_q;
    logic [15:0] ao2_q;
    logic        net_hit;

    always_comb begin
        net_hit = (i_net_addr == dnc_pkg::IDX_CMD)
               || (i_net_addr == dnc_pkg::IDX_SPEED)
               || (i_net_addr == dnc_pkg::IDX_DOUT)
               || (i_net_addr == dnc_pkg::IDX_AO1)
               || (i_net_addr == dnc_pkg::IDX_AO2);
    end

    // Only the network port reaches the storage
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cmd_q <= dnc_pkg::RST_CMD;
        end else if (i_net_wr && i_net_addr == dnc_pkg::IDX_CMD) begin
            cmd_q <= i_net_wdata & dnc_pkg::MASK_CMD;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            speed_q <= dnc_pkg::RST_SPEED;
        end else if (i_net_wr && i_net_addr == dnc_pkg::IDX_SPEED) begin
            speed_q <= i_net_wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            dout_q <= dnc_pkg::RST_DOUT;
        end else if (i_net_wr && i_net_addr == dnc_pkg::IDX_DOUT) begin
            dout_q <= i_net_wdata & dnc_pkg::MASK_DOUT;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ao1_q <= dnc_pkg::RST_AO;
            ao2_q <= dnc_pkg::RST_AO;
        end else if (i_net_wr) begin
            if (i_net_addr == dnc_pkg::IDX_AO1) begin
                ao1_q <= i_net_wdata;
            end
            if (i_net_addr == dnc_pkg::IDX_AO2) begin
                ao2_q <= i_net_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Port answers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_net_err     <= 1'b0;
            o_pan_refused <= 1'b0;
        end else begin
            o_net_err     <= i_net_wr && !net_hit;
            o_pan_refused <= i_pan_wr;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rd_data <= 16'h0000;
        end else begin
            unique case (i_rd_addr)
                dnc_pkg::IDX_CMD:   o_rd_data <= cmd_q;
                dnc_pkg::IDX_SPEED: o_rd_data <= speed_q;
                dnc_pkg::IDX_DOUT:  o_rd_data <= dout_q;
                dnc_pkg::IDX_AO1:   o_rd_data <= ao1_q;
                dnc_pkg::IDX_AO2:   o_rd_data <= ao2_q;
                default:            o_rd_data <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_cmd_active  <= 1'b0;
            o_run         <= 1'b0;
            o_enable      <= 1'b0;
            o_inch        <= 1'b0;
            o_remote      <= 1'b0;
            o_ramp2       <= 1'b0;
            o_quick_stop  <= 1'b0;
            o_fault_reset <= 1'b0;
        end else begin
            o_cmd_active  <= i_cmd_src_net;
            o_run         <= i_cmd_src_net && cmd_q[dnc_pkg::CMD_RUN];
            o_enable      <= i_cmd_src_net && cmd_q[dnc_pkg::CMD_EN];
            o_inch        <= i_cmd_src_net && cmd_q[dnc_pkg::CMD_INCH];
            o_remote      <= i_cmd_src_net && cmd_q[dnc_pkg::CMD_REM];
            o_ramp2       <= i_cmd_src_net && cmd_q[dnc_pkg::CMD_RAMP2];
            o_quick_stop  <= i_cmd_src_net && cmd_q[dnc_pkg::CMD_QSTOP];
            o_fault_reset <= i_cmd_src_net && i_fault
                          && cmd_q[dnc_pkg::CMD_FRST];
        end
    end

    // ------------------------------------------------------------
    // Speed reference
    // ------------------------------------------------------------
    logic [15:0]        sp_mag;
    logic [15+FQ_W:0]   sp_prod;
    logic [15+FQ_W:0]   sp_scaled;
    logic               sp_fwd;

    always_comb begin
        sp_mag    = speed_q[15] ? 16'(-speed_q) : speed_q;
        sp_prod   = (16+FQ_W)'(sp_mag) * (16+FQ_W)'(i_rated_freq);
        sp_scaled = sp_prod >> dnc_pkg::SPEED_FRAC;
        // Zero setpoint counts as positive
        sp_fwd    = cmd_q[dnc_pkg::CMD_DIR] ^ speed_q[15];
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_ref_valid <= 1'b0;
            o_ref_fwd   <= 1'b0;
            o_ref_freq  <= '0;
        end else begin
            o_ref_valid <= i_ref_src_net;
            o_ref_fwd   <= i_ref_src_net && sp_fwd;
            if (!i_ref_src_net) begin
                o_ref_freq <= '0;
            end else if (|sp_scaled[15+FQ_W:FQ_W]) begin
                o_ref_freq <= '1;
            end else begin
                o_ref_freq <= sp_scaled[FQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Discrete outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_do <= '0;
        end else begin
            for (int k = 0; k < DO_N; k++) begin
                o_do[k] <= i_do_sel_reg[k] ? dout_q[k] : i_do_other[k];
            end
        end
    end

    // ------------------------------------------------------------
    // Analog outputs
    // ------------------------------------------------------------
    dnc_ao_if ao1_bus ();
    dnc_ao_if ao2_bus ();

    assign ao1_bus.val1  = ao1_q;
    assign ao1_bus.val2  = ao2_q;
    assign ao1_bus.other = i_ao1_other;
    assign ao1_bus.sel   = i_ao1_sel;
    assign ao2_bus.val1  = ao1_q;
    assign ao2_bus.val2  = ao2_q;
    assign ao2_bus.other = i_ao2_other;
    assign ao2_bus.sel   = i_ao2_sel;
    assign o_ao1         = ao1_bus.level;
    assign o_ao2         = ao2_bus.level;

    dnc_ao_mux u_ao1 (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .ao      (ao1_bus.mux)
    );

    dnc_ao_mux u_ao2 (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .ao      (ao2_bus.mux)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    logic net_cmd_wr;
    assign net_cmd_wr = i_net_wr && i_net_addr == dnc_pkg::IDX_CMD;

    a_panel_no_write: assert property (
        i_pan_wr && !i_net_wr |=> $stable(cmd_q) && $stable(speed_q)
            && $stable(dout_q) && $stable(ao1_q) && $stable(ao2_q))
        else $error("panel write changed a register");

    a_panel_refused: assert property (
        i_pan_wr |=> o_pan_refused)
        else $error("panel write not refused");

    a_cmd_src_gate: assert property (
        !i_cmd_src_net |=> !o_run && !o_enable && !o_quick_stop
            && !o_fault_reset && !o_inch && !o_remote)
        else $error("command acted without network source");

    a_run_follows: assert property (
        net_cmd_wr ##1 (i_cmd_src_net && !i_net_wr)
            |=> o_run == $past(i_net_wdata[dnc_pkg::CMD_RUN], 2))
        else $error("run does not follow bit 0");

    a_enable_ramp: assert property (
        net_cmd_wr ##1 (i_cmd_src_net && !i_net_wr)
            |=> o_enable == $past(i_net_wdata[dnc_pkg::CMD_EN], 2)
             && o_ramp2 == $past(i_net_wdata[dnc_pkg::CMD_RAMP2], 2))
        else $error("enable or ramp bit not followed");

    a_inch_mode_stop: assert property (
        net_cmd_wr ##1 (i_cmd_src_net && !i_net_wr)
            |=> o_inch == $past(i_net_wdata[dnc_pkg::CMD_INCH], 2)
             && o_remote == $past(i_net_wdata[dnc_pkg::CMD_REM], 2)
             && o_quick_stop == $past(i_net_wdata[dnc_pkg::CMD_QSTOP], 2))
        else $error("inching, mode or quick stop bit not followed");

    a_speed_store: assert property (
        i_net_wr && i_net_addr == dnc_pkg::IDX_SPEED |=> speed_q == $past(i_net_wdata))
        else $error("network setpoint write not stored");

    a_fault_reset: assert property (
        o_fault_reset |-> $past(i_fault) && $past(cmd_q[dnc_pkg::CMD_FRST]))
        else $error("fault reset without fault");

    a_reserved_zero: assert property (
        (cmd_q & ~dnc_pkg::MASK_CMD) == 16'h0000
            && (dout_q & ~dnc_pkg::MASK_DOUT) == 16'h0000)
        else $error("reserved bit stored");

    a_ref_direction: assert property (
        i_ref_src_net |=> o_ref_fwd
            == ($past(cmd_q[dnc_pkg::CMD_DIR]) != $past(speed_q[15])))
        else $error("reference direction wrong");

    a_ref_rated: assert property (
        i_ref_src_net && speed_q == dnc_pkg::SPEED_RATED
            |=> o_ref_freq == $past(i_rated_freq))
        else $error("rated setpoint not rated frequency");

    a_ref_gate: assert property (
        !i_ref_src_net |=> !o_ref_valid && o_ref_freq == '0)
        else $error("reference used without network source");

    a_do_follow: assert property (
        i_do_sel_reg[0] |=> o_do[0] == $past(dout_q[0]))
        else $error("discrete output ignores register");

    a_ao_full: assert property (
        i_ao1_sel == dnc_pkg::AO_SEL_VAL1 && ao1_q == 16'h7fff
            |=> o_ao1 == dnc_pkg::AO_FULL)
        else $error("analog output not full scale");

    a_ao_clamp: assert property (
        i_ao1_sel == dnc_pkg::AO_SEL_VAL2 && ao2_q[15] |=> o_ao1 == dnc_pkg::AO_ZERO)
        else $error("negative analog value not clamped");

    c_net_run: cover property (net_cmd_wr ##2 o_run);
    c_panel_try: cover property (i_pan_wr ##1 o_pan_refused);
    c_reverse: cover property (o_ref_valid && !o_ref_fwd);
    c_fault_rst: cover property (o_fault_reset);
endmodule : dnc_cmd_regs

// *** hdl/dnc_pkg.sv ***
// Purpose: Shared constants for the drive network command registers
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes:   Register indices address the parameter ports
package dnc_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam int          REG_AW    = 3;
    localparam logic [2:0]  IDX_CMD   = 3'h0;
    localparam logic [2:0]  IDX_SPEED = 3'h1;
    localparam logic [2:0]  IDX_DOUT  = 3'h2;
    localparam logic [2:0]  IDX_AO1   = 3'h3;
    localparam logic [2:0]  IDX_AO2   = 3'h4;
    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CMD   = 16'h0000;
    localparam logic [15:0] RST_SPEED = 16'h0000;
    localparam logic [15:0] RST_DOUT  = 16'h0000;
    localparam logic [15:0] RST_AO    = 16'h0000;
    localparam logic [15:0] MASK_CMD  = 16'h00ff;
    localparam logic [15:0] MASK_DOUT = 16'h000f;
    // ------------------------------------------------------------
    // Command word bit positions
    // ------------------------------------------------------------
    localparam int CMD_RUN   = 0;
    localparam int CMD_EN    = 1;
    localparam int CMD_DIR   = 2;
    localparam int CMD_INCH  = 3;
    localparam int CMD_REM   = 4;
    localparam int CMD_RAMP2 = 5;
    localparam int CMD_QSTOP = 6;
    localparam int CMD_FRST  = 7;
    // ------------------------------------------------------------
    // Scaling
    // ------------------------------------------------------------
    localparam int          SPEED_FRAC = 13;
    localparam logic [15:0] SPEED_RATED = 16'h2000;
    localparam logic [14:0] AO_FULL    = 15'h7fff;
    localparam logic [14:0] AO_ZERO    = 15'h0000;

    typedef enum logic [1:0] {
        AO_SEL_OTHER,
        AO_SEL_VAL1,
        AO_SEL_VAL2
    } dnc_ao_sel_t;
endpackage : dnc_pkg

// *** test/dnc_cmd_regs_bench.sv ***
// Purpose: Self-checking bench for the network command registers
// Assumes: 10 MHz clock, sync reset held 8 cycles
// Notes:   Rated frequency 60 so reference figures stay small
`timescale 1ns/1ps
module dnc_cmd_regs_bench;
    logic                  i_mclk, i_reset, i_pan_wr, i_cmd_src_net, i_ref_src_net, i_fault;
    logic                  i_net_wr, o_net_err, o_pan_refused, o_run, o_enable, o_inch, o_remote;
    logic                  o_ramp2, o_quick_stop, o_fault_reset, o_cmd_active, o_ref_valid, o_ref_fwd;
    logic [2:0]            i_net_addr, i_pan_addr, i_rd_addr;
    logic [15:0]           i_net_wdata, i_pan_wdata, o_rd_data, i_rated_freq, o_ref_freq;
    logic [3:0]            i_do_sel_reg, i_do_other, o_do;
    logic [14:0]           i_ao1_other, i_ao2_other, o_ao1, o_ao2;
    dnc_pkg::dnc_ao_sel_t  i_ao1_sel, i_ao2_sel;
    int                    fails, total_checks, cycles;

    dnc_net_master i_master (.i_mclk(i_mclk), .o_net_wr(i_net_wr), .o_net_addr(i_net_addr),
                             .o_net_wdata(i_net_wdata));
    dnc_cmd_regs i_dut (.i_mclk, .i_reset, .i_net_wr, .i_net_addr, .i_net_wdata, .o_net_err,
        .i_pan_wr, .i_pan_addr, .i_pan_wdata, .o_pan_refused, .i_rd_addr, .o_rd_data,
        .i_cmd_src_net, .i_ref_src_net, .i_do_sel_reg, .i_do_other, .i_ao1_sel, .i_ao2_sel,
        .i_ao1_other, .i_ao2_other, .i_fault, .i_rated_freq, .o_run, .o_enable, .o_inch,
        .o_remote, .o_ramp2, .o_quick_stop, .o_fault_reset, .o_cmd_active, .o_ref_valid,
        .o_ref_fwd, .o_ref_freq, .o_do, .o_ao1, .o_ao2);

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic settle();
        repeat (2) @(posedge i_mclk);
        #1;
    endtask : settle

    task automatic read_check(input logic [2:0] idx, input logic [15:0] exp);
        @(posedge i_mclk);
        i_rd_addr <= idx;
        @(posedge i_mclk);
        #1;
        check(o_rd_data, exp);
    endtask : read_check

    function automatic logic [15:0] cmd_vec();
        return {9'h0, o_quick_stop, o_ramp2, o_remote, o_inch, 1'b0, o_enable, o_run};
    endfunction : cmd_vec

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_panel_refused();
        for (int i = 0; i < 5; i++) begin
            @(posedge i_mclk);
            i_pan_wr    <= 1'b1;
            i_pan_addr  <= 3'(i);
            i_pan_wdata <= 16'hffff;
            @(posedge i_mclk);
            i_pan_wr    <= 1'b0;
            #1;
            check({15'h0, o_pan_refused}, 16'h0001);
            read_check(3'(i), 16'h0000);
            check({15'h0, o_pan_refused}, 16'h0000);
        end
        i_master.write(3'h5, 16'h1234);
        #1;
        check({15'h0, o_net_err}, 16'h0001);
    endtask : test_panel_refused

    task automatic test_command_bits();
        for (int b = 0; b < 8; b++) begin
            i_master.write(dnc_pkg::IDX_CMD, 16'h0001 << b);
            settle();
            check(cmd_vec(), (16'h0001 << b) & 16'h007b);
            check({15'h0, o_fault_reset}, 16'h0000);
        end
        i_fault <= 1'b1;
        settle();
        check({15'h0, o_fault_reset}, 16'h0001);
        i_master.write(dnc_pkg::IDX_CMD, 16'hffff);
        read_check(dnc_pkg::IDX_CMD, 16'h00ff);
        i_cmd_src_net <= 1'b0;
        settle();
        check(cmd_vec() | {o_cmd_active, o_fault_reset, 14'h0}, 16'h0000);
        i_cmd_src_net <= 1'b1;
        i_fault       <= 1'b0;
        settle();
        check({15'h0, o_cmd_active}, 16'h0001);
        check(cmd_vec(), 16'h007b);
    endtask : test_command_bits

    task automatic test_speed_reference();
        logic [15:0] sp;
        int          num;
        for (int k = 0; k < 4; k++) begin
            num = (k == 0 || k == 3) ? 30 : 60;
            sp  = i_master.speed_code((k % 2 == 1) ? -num : num, 60);
            i_master.write(dnc_pkg::IDX_CMD, (k < 2) ? 16'h0004 : 16'h0000);
            i_master.write(dnc_pkg::IDX_SPEED, sp);
            settle();
            check({15'h0, o_ref_fwd}, (k == 0 || k == 3) ? 16'h0001 : 16'h0000);
            check(o_ref_freq, 16'(num));
            read_check(dnc_pkg::IDX_SPEED, sp);
        end
        i_ref_src_net <= 1'b0;
        settle();
        check({o_ref_valid, o_ref_fwd, o_ref_freq[13:0]}, 16'h0000);
        i_ref_src_net <= 1'b1;
        settle();
        check({15'h0, o_ref_valid}, 16'h0001);
    endtask : test_speed_reference

    task automatic test_outputs();
        i_master.write(dnc_pkg::IDX_DOUT, 16'hfffa);
        read_check(dnc_pkg::IDX_DOUT, 16'h000a);
        i_do_sel_reg <= 4'b0011;
        settle();
        check({12'h0, o_do}, 16'h0006);
        i_do_sel_reg <= 4'b1111;
        settle();
        check({12'h0, o_do}, 16'h000a);
        i_master.write(dnc_pkg::IDX_AO1, i_master.ao_code(100));
        i_master.write(dnc_pkg::IDX_AO2, 16'h8000);
        i_ao1_sel <= dnc_pkg::AO_SEL_VAL1;
        i_ao2_sel <= dnc_pkg::AO_SEL_VAL1;
        settle();
        check({o_ao1[7:0], o_ao2[7:0]}, 16'hffff);
        check({1'b0, o_ao1}, 16'h7fff);
        i_ao1_sel <= dnc_pkg::AO_SEL_VAL2;
        i_ao2_sel <= dnc_pkg::AO_SEL_OTHER;
        settle();
        check({1'b0, o_ao1}, 16'h0000);
        check({1'b0, o_ao2}, 16'h2aaa);
        i_ao1_sel <= dnc_pkg::dnc_ao_sel_t'(2'h3);
        settle();
        check({1'b0, o_ao1}, 16'h1555);
        read_check(dnc_pkg::IDX_AO2, 16'h8000);
    endtask : test_outputs

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        fails = 0; total_checks = 0; cycles = 0;
        i_reset = 1'b1; i_pan_wr = 1'b0; i_pan_addr = 3'h0; i_pan_wdata = 16'h0000;
        i_rd_addr = 3'h0; i_cmd_src_net = 1'b1; i_ref_src_net = 1'b1; i_fault = 1'b0;
        i_do_sel_reg = 4'h0; i_do_other = 4'h5; i_ao1_other = 15'h1555; i_ao2_other = 15'h2aaa;
        i_ao1_sel = dnc_pkg::AO_SEL_OTHER; i_ao2_sel = dnc_pkg::AO_SEL_OTHER;
        i_rated_freq = 16'h003c;
        repeat (8) @(posedge i_mclk);
        i_reset <= 1'b0;
        #1;
        check({o_run, o_enable, o_ref_fwd, o_do, o_ao1[8:0]}, 16'h0000);
        test_panel_refused();
        test_command_bits();
        test_speed_reference();
        test_outputs();
        tally_and_finish();
    end
endmodule : dnc_cmd_regs_bench

// *** test/dnc_net_master.sv ***
// Purpose: Network master model driving the parameter write port
// Assumes: Requests launched just after a rising edge of i_mclk
// Notes:   Lines idle with inverted data so stale values never match
`timescale 1ns/1ps
module dnc_net_master (
    input  wire logic        i_mclk,      // System clock
    output logic             o_net_wr,    // Write strobe
    output logic [2:0]       o_net_addr,  // Register index
    output logic [15:0]      o_net_wdata  // Write data
);
    initial begin
        o_net_wr    = 1'b0;
        o_net_addr  = 3'h7;
        o_net_wdata = 16'h0000;
    end

    // Signed setpoint where 8192 is rated frequency
    function automatic logic [15:0] speed_code(input int num, input int den);
        return 16'(num * 8192 / den);
    endfunction : speed_code

    // Analog value where 7fff is full scale
    function automatic logic [15:0] ao_code(input int pct);
        return 16'(pct * 32767 / 100);
    endfunction : ao_code

    // One whole word per strobe, held until the taking edge
    task automatic write(input logic [2:0] addr, input logic [15:0] data);
        @(posedge i_mclk);
        o_net_wr    <= 1'b1;
        o_net_addr  <= addr;
        o_net_wdata <= data;
        @(posedge i_mclk);
        o_net_wr    <= 1'b0;
        o_net_addr  <= ~addr;
        o_net_wdata <= ~data;
    endtask : write
endmodule : dnc_net_master
